// *** hw/tmc_pkg.sv ***
// package: register map, field positions, reset values and codes of the timer mode/control block
package tmc_pkg;
  localparam logic [23:0] ADDR_MODE     = 24'hffff8a;
  localparam logic [23:0] ADDR_CTRL_ONE = 24'hffff8b;
  localparam logic [23:0] ADDR_CTRL_TWO = 24'hffff90;
  localparam logic [23:0] ADDR_COUNTER  = 24'hffff96;
  localparam logic [23:0] ADDR_GRA      = 24'hffff98;
  localparam logic [23:0] ADDR_GRB      = 24'hffff9a;
  localparam logic [23:0] ADDR_GRC      = 24'hffff9c;
  localparam logic [23:0] ADDR_GRD      = 24'hffff9e;
  localparam logic [23:0] ADDR_STATUS   = 24'hffffa0;
  localparam int CNT_W = 16;
  // mode register
  localparam int MODE_RUN  = 7;
  localparam int MODE_BUFB = 5;
  localparam int MODE_BUFA = 4;
  localparam int MODE_DUAL = 3;
  localparam int MODE_PWM_MODE_D = 2;
  localparam int MODE_PWM_MODE_C = 1;
  localparam int MODE_PWM_MODE_B = 0;
  localparam logic [7:0] MODE_RESET = 8'h48;
  localparam logic [7:0] MODE_RSV   = 8'h40;
  // control register one
  localparam int C1_CLR    = 7;
  localparam int C1_CKS_HI = 6;
  localparam int C1_CKS_LO = 4;
  localparam logic [7:0] C1_RESET = 8'h00;
  // control register two
  localparam int C2_EDGE_HI = 7;
  localparam int C2_EDGE_LO = 6;
  localparam int C2_STOP    = 5;
  localparam logic [7:0] C2_RESET = 8'h18;
  localparam logic [7:0] C2_RSV   = 8'h18;
  // count clock codes
  localparam logic [2:0] CKS_DIV1 = 3'h0;
  localparam logic [2:0] CKS_DIV2 = 3'h1;
  localparam logic [2:0] CKS_DIV4 = 3'h2;
  localparam logic [2:0] CKS_DIV8 = 3'h3;
  localparam logic [2:0] CKS_DIV32 = 3'h4;
  localparam logic [2:0] CKS_EXT  = 3'h5;
  localparam int PRESCALE_W = 5;
  // trigger edge codes
  localparam logic [1:0] EDGE_OFF  = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
endpackage

// *** hw/tmc_channel.sv ***
// one channel: general register, optional buffer load, compare flag and output pin level
`timescale 1ns/10ps
`default_nettype none
module tmc_channel #(
  parameter int W = 16
) (
  input  wire logic         mclk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] count,
  input  wire logic         count_tick,
  input  wire logic         wr_reg,
  input  wire logic [W-1:0] wr_data,
  input  wire logic         load_buf,
  input  wire logic [W-1:0] buf_value,
  input  wire logic         out_level,
  input  wire logic         pwm_mode,
  input  wire logic         period_match,
  output logic [W-1:0]      reg_value,
  output logic              match,
  output logic              pin_out
);
  logic [W-1:0] reg_q, reg_d;
  logic         seen_q, seen_d;
  logic         lvl_q, lvl_d;

  assign match = count_tick && (count == reg_q);
  assign reg_value = reg_q;

  always_comb begin
    reg_d = reg_q;
    if (wr_reg) begin
      reg_d = wr_data;
    end else if (load_buf) begin
      reg_d = buf_value;
    end
    seen_d = seen_q | match;
    lvl_d = lvl_q;
    if (pwm_mode) begin
      // pwm: active on match, inactive on period
      if (match) begin
        lvl_d = 1'b1;
      end else if (period_match) begin
        lvl_d = 1'b0;
      end
    end else if (match) begin
      lvl_d = ~lvl_q;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      reg_q  <= '1;
      seen_q <= 1'b0;
      lvl_q  <= 1'b0;
    end else begin
      reg_q  <= reg_d;
      seen_q <= seen_d;
      lvl_q  <= lvl_d;
    end
  end

  // outside pwm mode, before first match the level bit drives the pin directly, no counter event needed
  always_comb begin
    if (pwm_mode) begin
      pin_out = lvl_q ^ ~out_level;
    end else if (!seen_q) begin
      pin_out = out_level;
    end else begin
      pin_out = lvl_q ^ out_level;
    end
  end
endmodule
`default_nettype wire

// *** hw/tmc_top.sv ***
// timer mode and control registers with the 16-bit counter they steer
//
// Behaviour
// - counter advances only while run bit b7 of mode register is one.
// - event-link start event also sets the run bit.
// - run bit cleared by writing zero, or stop-on-match channel a compare match in any mode.
// - reserved bits of mode and control two read as one.
// - buffer enable b makes register d the buffer of register b.
// - buffer enable a makes register c the buffer of register a.
// - dual-pwm select zero selects dual-pwm, ignoring io control and pwm bits.
// - dual-pwm select one gives timer or pwm mode per channel bits.
// - bits b2,b1,b0 put pins d,c,b into pwm mode when one, except c or d while serving as a buffer.
// - clear select one clears counter on channel a match.
// - clock select 000..100 picks phi, phi/2, phi/4, phi/8, phi/32.
// - clock select 101 counts rising edges of external clock pin.
// - outside pwm mode, output level bit drives pin until first compare match.
// - output level writes reach the pin immediately.
// - in pwm mode output level bit sets pin polarity.
// - trigger edge field: off, rising, falling, both edges.
// - trigger edge detection works only in dual-pwm mode.
// - stop on match halts counting on channel a match, any mode.
// - dual-pwm polarity bit b0 of pin b: zero active low, one active high; bits b1, b2 are the level bits of c, d.
// - counter wraps all ones to zero and flags overflow.
`timescale 1ns/10ps
`default_nettype none
module tmc_top #(
  parameter int CNT_W = tmc_pkg::CNT_W
) (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic [23:0] bus_addr,
  input  wire logic [15:0] bus_wdata,
  input  wire logic        bus_write,
  input  wire logic        bus_read,
  output logic [15:0]      bus_rdata,
  input  wire logic        event_link_start_select,
  input  wire logic        external_count_clock,
  input  wire logic        external_trigger_input,
  input  wire logic        io_control_valid,
  output logic             channel_pin_a,
  output logic             channel_pin_b,
  output logic             channel_pin_c,
  output logic             channel_pin_d,
  output logic             dual_pwm_active,
  output logic             trigger_event,
  output logic             overflow_event
);
  logic [7:0] mode_q, mode_d;
  logic [7:0] c1_q, c1_d;
  logic [7:0] c2_q, c2_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [tmc_pkg::PRESCALE_W-1:0] pre_q, pre_d;
  logic       ovf_q, ovf_d;
  logic [1:0] ext_sync_q, trg_sync_q;
  logic       ext_prev_q, trg_prev_q;
  logic [15:0] rdata_q, rdata_d;

  logic wr_mode, wr_c1, wr_c2, wr_cnt;
  logic [3:0] wr_gr;
  logic tick, run, dual_pwm;
  logic [3:0] match;
  logic [CNT_W-1:0] gr_val [4];
  logic [3:0] pins;
  logic [3:0] pwm_ch;
  logic [3:0] lvl;
  logic buf_load_a, buf_load_b;
  logic [2:0] cks;
  logic [1:0] edge_sel;
  logic ext_rise, trg_rise, trg_fall;

  assign wr_mode = bus_write && (bus_addr == tmc_pkg::ADDR_MODE);
  assign wr_c1   = bus_write && (bus_addr == tmc_pkg::ADDR_CTRL_ONE);
  assign wr_c2   = bus_write && (bus_addr == tmc_pkg::ADDR_CTRL_TWO);
  assign wr_cnt  = bus_write && (bus_addr == tmc_pkg::ADDR_COUNTER);
  assign wr_gr[0] = bus_write && (bus_addr == tmc_pkg::ADDR_GRA);
  assign wr_gr[1] = bus_write && (bus_addr == tmc_pkg::ADDR_GRB);
  assign wr_gr[2] = bus_write && (bus_addr == tmc_pkg::ADDR_GRC);
  assign wr_gr[3] = bus_write && (bus_addr == tmc_pkg::ADDR_GRD);

  assign run      = mode_q[tmc_pkg::MODE_RUN];
  assign dual_pwm = ~mode_q[tmc_pkg::MODE_DUAL];
  assign cks      = c1_q[tmc_pkg::C1_CKS_HI:tmc_pkg::C1_CKS_LO];
  assign edge_sel = c2_q[tmc_pkg::C2_EDGE_HI:tmc_pkg::C2_EDGE_LO];
  assign dual_pwm_active = dual_pwm;

  // pin inputs pass two flops; only the second stage is looked at
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ext_sync_q <= 2'h0;
      trg_sync_q <= 2'h0;
      ext_prev_q <= 1'b0;
      trg_prev_q <= 1'b0;
    end else begin
      ext_sync_q <= {ext_sync_q[0], external_count_clock};
      trg_sync_q <= {trg_sync_q[0], external_trigger_input};
      ext_prev_q <= ext_sync_q[1];
      trg_prev_q <= trg_sync_q[1];
    end
  end
  assign ext_rise = ext_sync_q[1] & ~ext_prev_q;
  assign trg_rise = trg_sync_q[1] & ~trg_prev_q;
  assign trg_fall = ~trg_sync_q[1] & trg_prev_q;

  always_comb begin
    trigger_event = 1'b0;
    if (dual_pwm) begin
      unique case (edge_sel)
        tmc_pkg::EDGE_OFF:  trigger_event = 1'b0;
        tmc_pkg::EDGE_RISE: trigger_event = trg_rise;
        tmc_pkg::EDGE_FALL: trigger_event = trg_fall;
        tmc_pkg::EDGE_BOTH: trigger_event = trg_rise | trg_fall;
      endcase
    end
  end

  // prescaler free runs so a divided tick lands on a fixed phase
  always_comb begin
    pre_d = pre_q + 1'b1;
    tick = 1'b0;
    unique case (cks)
      tmc_pkg::CKS_DIV1:  tick = 1'b1;
      tmc_pkg::CKS_DIV2:  tick = pre_q[0];
      tmc_pkg::CKS_DIV4:  tick = &pre_q[1:0];
      tmc_pkg::CKS_DIV8:  tick = &pre_q[2:0];
      tmc_pkg::CKS_DIV32: tick = &pre_q;
      tmc_pkg::CKS_EXT:   tick = ext_rise;
      // prohibited codes never count
      default:            tick = 1'b0;
    endcase
    tick = tick & run;
  end

  always_comb begin
    cnt_d = cnt_q;
    ovf_d = 1'b0;
    if (wr_cnt) begin
      cnt_d = bus_wdata[CNT_W-1:0];
    end else if (tick) begin
      if (c1_q[tmc_pkg::C1_CLR] && match[0]) begin
        cnt_d = '0;
      end else begin
        cnt_d = cnt_q + 1'b1;
        ovf_d = &cnt_q;
      end
    end
  end

  always_comb begin
    mode_d = mode_q;
    c1_d = c1_q;
    c2_d = c2_q;
    if (wr_mode) begin
      mode_d = bus_wdata[7:0] | tmc_pkg::MODE_RSV;
    end
    // stop on channel a match; any mode, and it also clears run
    if (c2_q[tmc_pkg::C2_STOP] && match[0]) begin
      mode_d[tmc_pkg::MODE_RUN] = 1'b0;
    end
    // start event beats a simultaneous stop or a written zero
    if (event_link_start_select) begin
      mode_d[tmc_pkg::MODE_RUN] = 1'b1;
    end
    if (wr_c1) begin
      c1_d = bus_wdata[7:0];
    end
    if (wr_c2) begin
      c2_d = bus_wdata[7:0] | tmc_pkg::C2_RSV;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mode_q <= tmc_pkg::MODE_RESET;
      c1_q   <= tmc_pkg::C1_RESET;
      c2_q   <= tmc_pkg::C2_RESET;
      cnt_q  <= '0;
      pre_q  <= '0;
      ovf_q  <= 1'b0;
    end else begin
      mode_q <= mode_d;
      c1_q   <= c1_d;
      c2_q   <= c2_d;
      cnt_q  <= cnt_d;
      pre_q  <= pre_d;
      ovf_q  <= ovf_d;
    end
  end
  assign overflow_event = ovf_q;

  // per-channel pwm selection; dual-pwm forces b into pwm and c, d out of it, io control ignored
  always_comb begin
    pwm_ch[0] = 1'b0;
    pwm_ch[1] = dual_pwm | (mode_q[tmc_pkg::MODE_PWM_MODE_B] & io_control_valid);
    pwm_ch[2] = ~dual_pwm & mode_q[tmc_pkg::MODE_PWM_MODE_C] & io_control_valid;
    pwm_ch[3] = ~dual_pwm & mode_q[tmc_pkg::MODE_PWM_MODE_D] & io_control_valid;
    lvl[0] = c1_q[0];
    lvl[1] = dual_pwm ? c2_q[0] : c1_q[1];
    lvl[2] = dual_pwm ? c2_q[1] : c1_q[2];
    lvl[3] = dual_pwm ? c2_q[2] : c1_q[3];
  end

  // buffers transfer on the compare match of the register they feed
  assign buf_load_a = mode_q[tmc_pkg::MODE_BUFA] & match[0];
  assign buf_load_b = mode_q[tmc_pkg::MODE_BUFB] & match[1];

  tmc_channel #(.W(CNT_W)) u_ch_a (
    .mclk(mclk), .reset_n(reset_n), .count(cnt_q), .count_tick(tick),
    .wr_reg(wr_gr[0]), .wr_data(bus_wdata[CNT_W-1:0]), .load_buf(buf_load_a),
    .buf_value(gr_val[2]), .out_level(lvl[0]), .pwm_mode(pwm_ch[0]),
    .period_match(match[0]), .reg_value(gr_val[0]), .match(match[0]), .pin_out(pins[0])
  );
  tmc_channel #(.W(CNT_W)) u_ch_b (
    .mclk(mclk), .reset_n(reset_n), .count(cnt_q), .count_tick(tick),
    .wr_reg(wr_gr[1]), .wr_data(bus_wdata[CNT_W-1:0]), .load_buf(buf_load_b),
    .buf_value(gr_val[3]), .out_level(lvl[1]), .pwm_mode(pwm_ch[1]),
    .period_match(match[0]), .reg_value(gr_val[1]), .match(match[1]), .pin_out(pins[1])
  );
  // c and d never load from a buffer; as buffers their pwm mode is switched off
  tmc_channel #(.W(CNT_W)) u_ch_c (
    .mclk(mclk), .reset_n(reset_n), .count(cnt_q), .count_tick(tick),
    .wr_reg(wr_gr[2]), .wr_data(bus_wdata[CNT_W-1:0]), .load_buf(1'b0),
    .buf_value(gr_val[2]), .out_level(lvl[2]),
    .pwm_mode(pwm_ch[2] & ~mode_q[tmc_pkg::MODE_BUFA]),
    .period_match(match[0]), .reg_value(gr_val[2]), .match(match[2]), .pin_out(pins[2])
  );
  tmc_channel #(.W(CNT_W)) u_ch_d (
    .mclk(mclk), .reset_n(reset_n), .count(cnt_q), .count_tick(tick),
    .wr_reg(wr_gr[3]), .wr_data(bus_wdata[CNT_W-1:0]), .load_buf(1'b0),
    .buf_value(gr_val[3]), .out_level(lvl[3]),
    .pwm_mode(pwm_ch[3] & ~mode_q[tmc_pkg::MODE_BUFB]),
    .period_match(match[0]), .reg_value(gr_val[3]), .match(match[3]), .pin_out(pins[3])
  );

  assign channel_pin_a = pins[0];
  assign channel_pin_b = pins[1];
  assign channel_pin_c = pins[2];
  assign channel_pin_d = pins[3];

  // read data registered one cycle after the strobe; unmapped reads zero
  always_comb begin
    rdata_d = 16'h0000;
    if (bus_read) begin
      unique case (bus_addr)
        tmc_pkg::ADDR_MODE:     rdata_d = {8'h00, mode_q};
        tmc_pkg::ADDR_CTRL_ONE: rdata_d = {8'h00, c1_q};
        tmc_pkg::ADDR_CTRL_TWO: rdata_d = {8'h00, c2_q};
        tmc_pkg::ADDR_COUNTER:  rdata_d = cnt_q;
        tmc_pkg::ADDR_GRA:      rdata_d = gr_val[0];
        tmc_pkg::ADDR_GRB:      rdata_d = gr_val[1];
        tmc_pkg::ADDR_GRC:      rdata_d = gr_val[2];
        tmc_pkg::ADDR_GRD:      rdata_d = gr_val[3];
        tmc_pkg::ADDR_STATUS:   rdata_d = {12'h000, pins};
        default:                rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end
  assign bus_rdata = rdata_q;
endmodule
`default_nettype wire

// *** dv/tmc_checker.sv ***
// checker: port-level assertions for the timer mode and control block
`timescale 1ns/10ps
`default_nettype none
module tmc_checker #(
  parameter int CNT_W = 16
) (
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic [23:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  input wire logic        bus_write,
  input wire logic        bus_read,
  input wire logic [15:0] bus_rdata,
  input wire logic        event_link_start_select,
  input wire logic        external_count_clock,
  input wire logic        external_trigger_input,
  input wire logic        io_control_valid,
  input wire logic        channel_pin_a,
  input wire logic        channel_pin_b,
  input wire logic        channel_pin_c,
  input wire logic        channel_pin_d,
  input wire logic        dual_pwm_active,
  input wire logic        trigger_event,
  input wire logic        overflow_event
);
  // shadow of the run history and edge field, rebuilt from bus traffic and the start event
  logic       ran_q;
  logic       ran_d;
  logic [1:0] edge_q;
  logic [1:0] edge_d;
  wire logic  wr_m = bus_write && bus_addr == tmc_pkg::ADDR_MODE;
  wire logic  wr_2 = bus_write && bus_addr == tmc_pkg::ADDR_CTRL_TWO;
  always_comb begin
    ran_d = ran_q | (wr_m & bus_wdata[7]) | event_link_start_select;
    edge_d = wr_2 ? bus_wdata[7:6] : edge_q;
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ran_q <= 1'b0;
      edge_q <= 2'h0;
    end else begin
      ran_q <= ran_d;
      edge_q <= edge_d;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_mode_rsv: assert property ($past(bus_read) && $past(bus_addr) == tmc_pkg::ADDR_MODE
    |-> bus_rdata[6]) else $error("mode reserved bit read low");
  a_ctl2_rsv: assert property ($past(bus_read) && $past(bus_addr) == tmc_pkg::ADDR_CTRL_TWO
    |-> bus_rdata[4:3] == 2'h3) else $error("control two reserved bits read low");
  a_dual_on: assert property (wr_m && !bus_wdata[3] |=> dual_pwm_active)
    else $error("dual pwm not entered");
  a_dual_off: assert property (wr_m && bus_wdata[3] |=> !dual_pwm_active)
    else $error("dual pwm not left");
  // before any run no match can occur, so pin a follows its level bit at once
  a_level_pin: assert property (bus_write && bus_addr == tmc_pkg::ADDR_CTRL_ONE && !ran_d
    |=> channel_pin_a == $past(bus_wdata[0])) else $error("pin a not at level bit");
  a_trig_mode: assert property (!dual_pwm_active |-> !trigger_event)
    else $error("trigger outside dual pwm");
  a_trig_off: assert property (dual_pwm_active && edge_q == 2'h0 |-> !trigger_event)
    else $error("trigger while disabled");
  a_trig_rise: assert property (dual_pwm_active && edge_q == 2'h1 && $rose(external_trigger_input)
    |-> ##[1:4] trigger_event) else $error("rising trigger missed");
  a_ovf_single: assert property (overflow_event |=> !overflow_event)
    else $error("overflow longer than one cycle");
  c_ovf: cover property (overflow_event);
  c_trig: cover property (trigger_event);
  c_dual: cover property (dual_pwm_active);
endmodule
`default_nettype wire

// *** dv/test_tmc_top.sv ***
// testbench: register-level scenarios for the timer mode and control block
`timescale 1ns/10ps
`default_nettype none
module test_tmc_top;
  logic        mclk, reset_n, bus_write, bus_read;
  logic        event_link_start_select, external_count_clock;
  logic        external_trigger_input, io_control_valid;
  logic [23:0] bus_addr;
  logic [15:0] bus_wdata, bus_rdata;
  logic        channel_pin_a, channel_pin_b, channel_pin_c, channel_pin_d;
  logic        dual_pwm_active, trigger_event, overflow_event;
  int          mismatches, num_checks, trg_cnt, ovf_cnt, i, n0;
  tmc_top DUT (.*);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (trigger_event === 1'b1) trg_cnt++;
    if (overflow_event === 1'b1) ovf_cnt++;
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  // the gap cycle after each strobe keeps back-to-back calls from double-driving it
  task automatic wr(input logic [23:0] a, input logic [15:0] d);
    bus_addr <= a;
    bus_wdata <= d;
    bus_write <= 1'b1;
    @(posedge mclk);
    bus_write <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [23:0] a, input logic [15:0] e, input string nm);
    bus_addr <= a;
    bus_read <= 1'b1;
    @(posedge mclk);
    bus_read <= 1'b0;
    #1 chk(nm, e, bus_rdata);
    @(posedge mclk);
  endtask
  // counts k+2 edges: from the edge after the start write to the stop write
  task automatic run(input int k);
    wr(tmc_pkg::ADDR_MODE, 16'h00c8);
    repeat (k) @(posedge mclk);
    wr(tmc_pkg::ADDR_MODE, 16'h0048);
  endtask
  task automatic pulse_trig();
    n0 = trg_cnt;
    external_trigger_input <= 1'b1;
    repeat (6) @(posedge mclk);
    external_trigger_input <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask
  initial begin
    repeat (5000) @(posedge mclk);
    mismatches++;
    test_done();
  end
  initial begin
    {reset_n, bus_write, bus_read, event_link_start_select} = 4'h0;
    {external_count_clock, external_trigger_input} = 2'h0;
    io_control_valid = 1'b1;
    bus_addr = 24'h000000;
    bus_wdata = 16'h0000;
    {trg_cnt, ovf_cnt, mismatches, num_checks} = '0;
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    rd(tmc_pkg::ADDR_MODE, 16'h0048, "mode reset");
    rd(tmc_pkg::ADDR_CTRL_ONE, 16'h0000, "ctrl1 reset");
    rd(tmc_pkg::ADDR_CTRL_TWO, 16'h0018, "ctrl2 reset");
    rd(24'hffff8c, 16'h0000, "unmapped");
    wr(tmc_pkg::ADDR_CTRL_TWO, 16'h0000);
    rd(tmc_pkg::ADDR_CTRL_TWO, 16'h0018, "ctrl2 reserved");
    // level bits before any match, no counter event needed
    wr(tmc_pkg::ADDR_CTRL_ONE, 16'h000a);
    chk("pins", 16'h000a, {12'h000, channel_pin_d, channel_pin_c, channel_pin_b, channel_pin_a});
    wr(tmc_pkg::ADDR_CTRL_ONE, 16'h0005);
    rd(tmc_pkg::ADDR_STATUS, 16'h0005, "pin status");
    for (i = 0; i < 5; i++) begin
      wr(tmc_pkg::ADDR_CTRL_ONE, 16'(i << 4));
      wr(tmc_pkg::ADDR_COUNTER, 16'h0000);
      run(62);
      rd(tmc_pkg::ADDR_COUNTER, 16'(64 >> (i == 4 ? 5 : i)), "prescaled count");
      repeat (4) @(posedge mclk);
      rd(tmc_pkg::ADDR_COUNTER, 16'(64 >> (i == 4 ? 5 : i)), "held count");
    end
    wr(tmc_pkg::ADDR_CTRL_ONE, 16'h0050);
    wr(tmc_pkg::ADDR_COUNTER, 16'h0000);
    wr(tmc_pkg::ADDR_MODE, 16'h00c8);
    repeat (5) begin
      external_count_clock <= 1'b1;
      repeat (4) @(posedge mclk);
      external_count_clock <= 1'b0;
      repeat (4) @(posedge mclk);
    end
    wr(tmc_pkg::ADDR_MODE, 16'h0048);
    rd(tmc_pkg::ADDR_COUNTER, 16'h0005, "external count");
    wr(tmc_pkg::ADDR_CTRL_ONE, 16'h0000);
    wr(tmc_pkg::ADDR_COUNTER, 16'hfffe);
    run(2);
    rd(tmc_pkg::ADDR_COUNTER, 16'h0002, "wrapped count");
    chk("overflow pulses", 16'h0001, 16'(ovf_cnt));
    wr(tmc_pkg::ADDR_CTRL_ONE, 16'h0080);
    wr(tmc_pkg::ADDR_GRA, 16'h0003);
    wr(tmc_pkg::ADDR_COUNTER, 16'h0000);
    run(8);
    rd(tmc_pkg::ADDR_COUNTER, 16'h0002, "cleared count");
    rd(tmc_pkg::ADDR_GRA, 16'h0003, "unbuffered gra");
    wr(tmc_pkg::ADDR_CTRL_ONE, 16'h0000);
    wr(tmc_pkg::ADDR_CTRL_TWO, 16'h0038);
    wr(tmc_pkg::ADDR_GRA, 16'h0005);
    wr(tmc_pkg::ADDR_COUNTER, 16'h0000);
    wr(tmc_pkg::ADDR_MODE, 16'h00c8);
    repeat (20) @(posedge mclk);
    rd(tmc_pkg::ADDR_MODE, 16'h0048, "stopped on match");
    wr(tmc_pkg::ADDR_MODE, 16'h00c8);
    rd(tmc_pkg::ADDR_MODE, 16'h00c8, "resumed");
    wr(tmc_pkg::ADDR_MODE, 16'h0048);
    wr(tmc_pkg::ADDR_CTRL_TWO, 16'h0018);
    event_link_start_select <= 1'b1;
    @(posedge mclk);
    event_link_start_select <= 1'b0;
    @(posedge mclk);
    rd(tmc_pkg::ADDR_MODE, 16'h00c8, "event start");
    wr(tmc_pkg::ADDR_MODE, 16'h0000);
    rd(tmc_pkg::ADDR_MODE, 16'h0040, "dual mode");
    chk("dual active", 16'h0001, 16'(dual_pwm_active));
    for (i = 0; i < 4; i++) begin
      wr(tmc_pkg::ADDR_CTRL_TWO, 16'(i << 6) | 16'h0018);
      pulse_trig();
      chk("trigger count", 16'(i == 0 ? 0 : (i == 3 ? 2 : 1)), 16'(trg_cnt - n0));
    end
    wr(tmc_pkg::ADDR_MODE, 16'h0048);
    chk("dual active", 16'h0000, 16'(dual_pwm_active));
    pulse_trig();
    chk("timer mode trigger", 16'h0000, 16'(trg_cnt - n0));
    // both buffers on: c feeds a on match a, d feeds b on match b
    wr(tmc_pkg::ADDR_CTRL_ONE, 16'h0080);
    wr(tmc_pkg::ADDR_GRA, 16'h0003);
    wr(tmc_pkg::ADDR_GRB, 16'h0002);
    wr(tmc_pkg::ADDR_GRC, 16'h0007);
    wr(tmc_pkg::ADDR_GRD, 16'h0009);
    wr(tmc_pkg::ADDR_COUNTER, 16'h0000);
    wr(tmc_pkg::ADDR_MODE, 16'h00f8);
    repeat (8) @(posedge mclk);
    wr(tmc_pkg::ADDR_MODE, 16'h0048);
    rd(tmc_pkg::ADDR_GRA, 16'h0007, "buffered gra");
    rd(tmc_pkg::ADDR_GRB, 16'h0009, "buffered grb");
    test_done();
  end
endmodule
bind tmc_top tmc_checker #(.CNT_W(CNT_W)) u_chk (.*);
`default_nettype wire
